// ### pkg/usbirq_pkg.sv
// Register map, vectors and constants of the USB interrupt and buffer block
package usbirq_pkg;
	localparam logic [15:0] ADDR_ISO_OUT_DATA = 16'hc760;
	localparam logic [15:0] ADDR_ISO_IN_DATA = 16'hc768;
	localparam logic [15:0] ADDR_ISO_CNT_HIGH = 16'hc770;
	localparam logic [15:0] ADDR_ISO_CNT_LOW = 16'hc771;
	localparam logic [15:0] ADDR_ISO_CRC_ERR = 16'hc7a0;
	localparam logic [15:0] ADDR_ISO_ZERO_LEN = 16'hc7a2;
	localparam logic [15:0] ADDR_IN_REQ = 16'hc7a9;
	localparam logic [15:0] ADDR_OUT_REQ = 16'hc7aa;
	localparam logic [15:0] ADDR_BUS_REQ = 16'hc7ab;
	localparam logic [15:0] ADDR_IN_EN = 16'hc7ac;
	localparam logic [15:0] ADDR_OUT_EN = 16'hc7ad;
	localparam logic [15:0] ADDR_BUS_EN = 16'hc7ae;
	localparam logic [15:0] ADDR_IVEC = 16'hc7a8;
	// Bulk buffer window bases, endpoints 0..5
	localparam logic [15:0] IN_BUF_BASE [6] = '{16'hc700, 16'hc680,
		16'hc600, 16'hc580, 16'hc500, 16'hc480};
	localparam logic [15:0] OUT_BUF_BASE [6] = '{16'hc6c0, 16'hc640,
		16'hc5c0, 16'hc540, 16'hc4c0, 16'hc440};
	localparam int BUF_WIN_BYTES = 64;
	localparam int BUF_MEM_BYTES = 512;
	localparam int ISO_FIFO_BYTES = 128;
	// Bus event bit positions
	localparam int BIT_SETUP_DATA = 0;
	localparam int BIT_SOF = 1;
	localparam int BIT_SETUP_TOK = 2;
	localparam int BIT_SUSPEND = 3;
	localparam int BIT_BUS_RESET = 4;
	// Vectors
	localparam logic [7:0] VEC_BUS_STEP = 8'h04;
	localparam logic [7:0] VEC_EP_BASE = 8'h18;
	localparam logic [7:0] VEC_EP_STEP = 8'h08;
	localparam logic [7:0] VEC_OUT_OFS = 8'h04;
	localparam logic [7:0] VEC_NONE = 8'h00;
	localparam logic [5:0] MASK6_RESET = 6'h00;
	localparam logic [4:0] MASK5_RESET = 5'h00;
	localparam int IRQ_PULSE_CYCLES = 2;
endpackage : usbirq_pkg

// ### logic/usbirq_regs.sv
// USB interrupt vectoring, request/enable registers, ISO EP8 ports, buffers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module usbirq_regs
	import usbirq_pkg::*;
#(
	parameter int FIFO_DEPTH = ISO_FIFO_BYTES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [5:0] i_in_ack,
	input wire logic [5:0] i_out_ok,
	input wire logic [4:0] i_bus_event,
	input wire logic i_iso_out_valid,
	input wire logic [7:0] i_iso_out_byte,
	input wire logic i_iso_out_end,
	input wire logic i_iso_out_crc_bad,
	input wire logic i_iso_in_pop,
	output logic [7:0] o_iso_in_byte,
	output logic [9:0] o_iso_in_count,
	output logic o_iso_out_full,
	output logic o_buf_sel,
	output logic o_buf_is_in,
	output logic [2:0] o_buf_ep,
	output logic [5:0] o_buf_ofs,
	output logic [7:0] o_ivec,
	output logic o_usb_irq
);
	logic [5:0] in_req_q, out_req_q, in_en_q, out_en_q;
	logic [5:0] in_left, out_left;
	logic [4:0] bus_req_q, bus_en_q, bus_left;
	logic [7:0] ivec_q;
	logic active_q;
	logic [1:0] pulse_cnt_q;
	logic irq_q;
	logic retrig_q;
	logic [7:0] out_head, in_head;
	logic [9:0] in_cnt, out_frame_cnt_q;
	logic out_full, out_push, in_pop;
	logic [9:0] last_cnt_q;
	logic crc_frame_q, crc_err_q, zero_len_q, zero_frame_q;
	logic [7:0] rdata_q, in_byte_q;

	////////////////////////////////////////////////////////////////////////
	// Decode
	wire wr_in_req = i_wr && i_addr == ADDR_IN_REQ;
	wire wr_out_req = i_wr && i_addr == ADDR_OUT_REQ;
	wire wr_bus_req = i_wr && i_addr == ADDR_BUS_REQ;
	wire wr_iso_in = i_wr && i_addr == ADDR_ISO_IN_DATA;
	wire rd_iso_out = i_rd && i_addr == ADDR_ISO_OUT_DATA;
	wire sof = i_bus_event[BIT_SOF];
	wire wr_in_en = i_wr && i_addr == ADDR_IN_EN;
	wire wr_out_en = i_wr && i_addr == ADDR_OUT_EN;
	wire wr_bus_en = i_wr && i_addr == ADDR_BUS_EN;
	// Disabled flags keep recording but are hidden here
	wire [5:0] in_act = in_req_q & in_en_q;
	wire [5:0] out_act = out_req_q & out_en_q;
	wire [4:0] bus_act = bus_req_q & bus_en_q;
	wire any_act = |{in_act, out_act, bus_act};
	wire any_left = |{in_left, out_left, bus_left};
	wire any_clr = ((wr_in_req || wr_out_req) && |i_wdata[5:0])
		|| (wr_bus_req && |i_wdata[4:0]);

	// Set wins over a clear in the same cycle
	usbirq_src_bank #(.W(6)) in_bank (
		.i_sys_clk,
		.i_rst_n,
		.i_set(i_in_ack),
		.i_clr_wr(wr_in_req),
		.i_en_wr(wr_in_en),
		.i_wdata(i_wdata[5:0]),
		.o_req(in_req_q),
		.o_en(in_en_q),
		.o_left(in_left)
	);
	usbirq_src_bank #(.W(6)) out_bank (
		.i_sys_clk,
		.i_rst_n,
		.i_set(i_out_ok),
		.i_clr_wr(wr_out_req),
		.i_en_wr(wr_out_en),
		.i_wdata(i_wdata[5:0]),
		.o_req(out_req_q),
		.o_en(out_en_q),
		.o_left(out_left)
	);
	usbirq_src_bank #(.W(5)) bus_bank (
		.i_sys_clk,
		.i_rst_n,
		.i_set(i_bus_event),
		.i_clr_wr(wr_bus_req),
		.i_en_wr(wr_bus_en),
		.i_wdata(i_wdata[4:0]),
		.o_req(bus_req_q),
		.o_en(bus_en_q),
		.o_left(bus_left)
	);

	////////////////////////////////////////////////////////////////////////
	// Priority encoder, lowest code wins
	logic [7:0] vec;
	always_comb begin
		vec = VEC_NONE;
		for (int n = 5; n >= 0; n--) begin
			if (out_act[n]) begin
				vec = VEC_EP_BASE + VEC_EP_STEP * 8'(n) + VEC_OUT_OFS;
			end
			if (in_act[n]) begin
				vec = VEC_EP_BASE + VEC_EP_STEP * 8'(n);
			end
		end
		for (int b = 4; b >= 0; b--) begin
			if (bus_act[b]) begin
				vec = VEC_BUS_STEP * 8'(b);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pulse generation. A new pulse fires when something becomes pending
	// from idle, or when software clears a flag while others remain.
	wire fire = (any_act && !active_q) || (any_clr && any_left);
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ivec_q <= VEC_NONE;
			active_q <= 1'b0;
			retrig_q <= 1'b0;
			pulse_cnt_q <= 2'd0;
			irq_q <= 1'b0;
		end else begin
			ivec_q <= vec;
			// After a clear only the survivors count as already served
			active_q <= any_clr ? any_left : any_act;
			if ((fire || retrig_q) && !irq_q) begin
				retrig_q <= 1'b0;
				pulse_cnt_q <= 2'(IRQ_PULSE_CYCLES);
				irq_q <= 1'b1;
			end else begin
				// A source arriving mid-pulse waits for the low phase,
				// so every pulse keeps an edge of its own
				if (fire) begin
					retrig_q <= 1'b1;
				end
				if (pulse_cnt_q != 2'd0) begin
					pulse_cnt_q <= pulse_cnt_q - 2'd1;
					irq_q <= pulse_cnt_q != 2'd1;
				end else begin
					irq_q <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ISO OUT endpoint 8: bytes pushed by the link, read by the MCU.
	// Errored packets are still stored; only the flag reports them.
	usbirq_byte_fifo #(.DEPTH(FIFO_DEPTH), .CW(10)) out_fifo (
		.i_sys_clk,
		.i_rst_n,
		.i_push(i_iso_out_valid),
		.i_data(i_iso_out_byte),
		.i_pop(rd_iso_out),
		.o_head(out_head),
		.o_count(),
		.o_full(out_full),
		.o_take(),
		.o_store(out_push)
	);
	usbirq_byte_fifo #(.DEPTH(FIFO_DEPTH), .CW(10)) in_fifo (
		.i_sys_clk,
		.i_rst_n,
		.i_push(wr_iso_in),
		.i_data(i_wdata),
		.i_pop(i_iso_in_pop),
		.o_head(in_head),
		.o_count(in_cnt),
		.o_full(),
		.o_take(in_pop),
		.o_store()
	);
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			out_frame_cnt_q <= 10'd0;
			last_cnt_q <= 10'd0;
			crc_frame_q <= 1'b0;
			crc_err_q <= 1'b0;
			zero_frame_q <= 1'b0;
			zero_len_q <= 1'b0;
			in_byte_q <= 8'h00;
		end else begin
			if (in_pop) begin
				in_byte_q <= in_head;
			end
			// Status gathered through the frame, published at SOF
			if (sof) begin
				last_cnt_q <= out_frame_cnt_q;
				crc_err_q <= crc_frame_q;
				zero_len_q <= zero_frame_q;
				out_frame_cnt_q <= 10'd0;
				crc_frame_q <= 1'b0;
				zero_frame_q <= 1'b0;
			end else begin
				if (out_push) begin
					out_frame_cnt_q <= out_frame_cnt_q + 10'd1;
				end
				if (i_iso_out_end) begin
					crc_frame_q <= i_iso_out_crc_bad;
					zero_frame_q <= out_frame_cnt_q == 10'd0 && !out_push;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bulk buffer window decode
	logic bsel, bin;
	logic [2:0] bep;
	always_comb begin
		bsel = 1'b0;
		bin = 1'b0;
		bep = 3'd0;
		for (int e = 0; e < 6; e++) begin
			if (i_addr[15:6] == IN_BUF_BASE[e][15:6]) begin
				bsel = 1'b1;
				bin = 1'b1;
				bep = 3'(e);
			end
			if (i_addr[15:6] == OUT_BUF_BASE[e][15:6]) begin
				bsel = 1'b1;
				bin = 1'b0;
				bep = 3'(e);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; data appears the cycle after the strobe, unmapped reads 0
	logic [7:0] rmux;
	always_comb begin
		case (i_addr)
			ADDR_ISO_OUT_DATA: rmux = out_head;
			ADDR_ISO_CNT_HIGH: rmux = {6'h00, last_cnt_q[9:8]};
			ADDR_ISO_CNT_LOW: rmux = last_cnt_q[7:0];
			ADDR_ISO_CRC_ERR: rmux = {7'h00, crc_err_q};
			ADDR_ISO_ZERO_LEN: rmux = {7'h00, zero_len_q};
			ADDR_IVEC: rmux = ivec_q;
			ADDR_IN_REQ: rmux = {2'b00, in_req_q};
			ADDR_OUT_REQ: rmux = {2'b00, out_req_q};
			ADDR_BUS_REQ: rmux = {3'b000, bus_req_q};
			ADDR_IN_EN: rmux = {2'b00, in_en_q};
			ADDR_OUT_EN: rmux = {2'b00, out_en_q};
			ADDR_BUS_EN: rmux = {3'b000, bus_en_q};
			default: rmux = 8'h00;
		endcase
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= i_rd ? rmux : 8'h00;
		end
	end

	assign o_rdata = rdata_q;
	assign o_ivec = ivec_q;
	assign o_usb_irq = irq_q;
	assign o_iso_in_byte = in_byte_q;
	assign o_iso_in_count = in_cnt;
	assign o_iso_out_full = out_full;
	assign o_buf_sel = bsel && (i_rd || i_wr);
	assign o_buf_is_in = bin;
	assign o_buf_ep = bep;
	assign o_buf_ofs = i_addr[5:0];
endmodule : usbirq_regs

////////////////////////////////////////////////////////////////////////
// One bank of request flags with its enable register
module usbirq_src_bank #(
	parameter int W = 6
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_set,
	input wire logic i_clr_wr,
	input wire logic i_en_wr,
	input wire logic [W-1:0] i_wdata,
	output logic [W-1:0] o_req,
	output logic [W-1:0] o_en,
	output logic [W-1:0] o_left
);
	logic [W-1:0] req_q, en_q;
	wire [W-1:0] clr = i_clr_wr ? i_wdata : '0;
	// Set wins so an event landing on a clear is not lost
	wire [W-1:0] req_d = (req_q & ~clr) | i_set;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			req_q <= '0;
			en_q <= '0;
		end else begin
			req_q <= req_d;
			if (i_en_wr) begin
				en_q <= i_wdata;
			end
		end
	end
	assign o_req = req_q;
	assign o_en = en_q;
	// Enabled flags that survive this cycle's clear
	assign o_left = req_q & ~clr & en_q;
endmodule : usbirq_src_bank

////////////////////////////////////////////////////////////////////////
// Byte FIFO for one isochronous direction. Pushes into a full FIFO and
// pops from an empty one are dropped; depth must be a power of two.
module usbirq_byte_fifo #(
	parameter int DEPTH = 128,
	parameter int CW = 10
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_push,
	input wire logic [7:0] i_data,
	input wire logic i_pop,
	output logic [7:0] o_head,
	output logic [CW-1:0] o_count,
	output logic o_full,
	output logic o_take,
	output logic o_store
);
	localparam int AW = $clog2(DEPTH);
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [CW-1:0] cnt_q;
	wire full = cnt_q == CW'(DEPTH);
	wire store = i_push && !full;
	wire take = i_pop && cnt_q != '0;
	always_ff @(posedge i_sys_clk) begin
		if (store) begin
			mem[wp_q] <= i_data;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (store) begin
				wp_q <= wp_q + 1'b1;
			end
			if (take) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + CW'(store) - CW'(take);
		end
	end
	assign o_head = mem[rp_q];
	assign o_count = cnt_q;
	assign o_full = full;
	assign o_take = take;
	assign o_store = store;
endmodule : usbirq_byte_fifo

// ### tb/usbirq_regs_chk.sv
// Port assertions for the USB interrupt and buffer register block
`timescale 1ns/1ps
module usbirq_chk
	import usbirq_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_buf_sel,
	input wire logic o_buf_is_in,
	input wire logic [2:0] o_buf_ep,
	input wire logic [7:0] o_ivec,
	input wire logic o_usb_irq
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	logic acc;
	assign acc = i_wr | i_rd;
	in0_win_a: assert property (
		acc && i_addr[15:6] == 10'h31c |-> o_buf_sel && o_buf_is_in
		&& o_buf_ep == 3'h0) else $error("ep0 IN window misdecoded");
	in5_win_a: assert property (
		acc && i_addr[15:6] == 10'h312 |-> o_buf_sel && o_buf_is_in
		&& o_buf_ep == 3'h5) else $error("ep5 IN window misdecoded");
	out0_win_a: assert property (
		acc && i_addr[15:6] == 10'h31b |-> o_buf_sel && !o_buf_is_in
		&& o_buf_ep == 3'h0) else $error("ep0 OUT window misdecoded");
	out5_win_a: assert property (
		acc && i_addr[15:6] == 10'h311 |-> o_buf_sel && !o_buf_is_in
		&& o_buf_ep == 3'h5) else $error("ep5 OUT window misdecoded");
	bus_req_a: assert property ($past(i_rd) && $past(i_addr) == 16'hc7ab
		|-> o_rdata[7:5] == 3'h0) else $error("bus flags upper bits set");
	bus_en_a: assert property ($past(i_rd) && $past(i_addr) == 16'hc7ae
		|-> o_rdata[7:5] == 3'h0) else $error("bus enable upper bits set");
	iso_err_a: assert property ($past(i_rd) && $past(i_addr) == 16'hc7a0
		|-> o_rdata[7:1] == 7'h00) else $error("iso error upper bits set");
	vec_form_a: assert property (
		o_ivec[1:0] == 2'h0 && o_ivec <= 8'h44 && o_ivec != 8'h14)
		else $error("vector outside code set");
	irq_pulse_a: assert property (
		$rose(o_usb_irq) |=> o_usb_irq ##[1:6] !o_usb_irq)
		else $error("interrupt pulse malformed");
endmodule : usbirq_chk

bind usbirq_regs usbirq_chk chk (.i_sys_clk, .i_rst_n, .i_addr, .i_wr,
	.i_rd, .o_rdata, .o_buf_sel, .o_buf_is_in, .o_buf_ep, .o_ivec, .o_usb_irq);

// ### tb/usbirq_link_model.sv
// Link-side model: bus events, ISO OUT packets and ISO IN pops
`timescale 1ns/1ps
module usbirq_link_model (
	input wire logic i_sys_clk,
	output logic [5:0] o_in_ack,
	output logic [5:0] o_out_ok,
	output logic [4:0] o_bus_event,
	output logic o_valid,
	output logic [7:0] o_byte,
	output logic o_end,
	output logic o_crc_bad,
	output logic o_pop
);
	logic [7:0] q [$];
	initial begin
		{o_in_ack, o_out_ok, o_bus_event, o_valid, o_end, o_pop} = '0;
		{o_crc_bad, o_byte} = 9'h05a;
	end
	task automatic ev(input logic [16:0] v);
		@(posedge i_sys_clk);
		{o_bus_event, o_out_ok, o_in_ack} <= v;
		@(posedge i_sys_clk);
		{o_bus_event, o_out_ok, o_in_ack} <= '0;
	endtask : ev
	// Random gaps model a slow link; idle data shows a changing pattern
	task automatic pkt(input int n, input logic bad);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			@(posedge i_sys_clk);
			b = $urandom;
			q.push_back(b);
			o_byte <= b;
			o_valid <= 1'b1;
			@(posedge i_sys_clk);
			o_valid <= 1'b0;
			o_byte <= ~b;
			repeat ($urandom_range(2)) @(posedge i_sys_clk);
		end
		@(posedge i_sys_clk);
		o_end <= 1'b1;
		o_crc_bad <= bad;
		@(posedge i_sys_clk);
		o_end <= 1'b0;
		o_crc_bad <= ~bad;
	endtask : pkt
	task automatic pop();
		@(posedge i_sys_clk);
		o_pop <= 1'b1;
		@(posedge i_sys_clk);
		o_pop <= 1'b0;
	endtask : pop
endmodule : usbirq_link_model

// ### tb/tb_top.sv
// Self-checking bench for the USB interrupt and buffer register block
`timescale 1ns/1ps
module tb_top;
	import usbirq_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [5:0] in_ack, out_ok;
	logic [4:0] bus_ev;
	logic iv, ie, ic, ip, o_usb_irq;
	logic [7:0] ib, o_rdata, o_ivec, o_iso_in_byte, v;
	logic [9:0] o_iso_in_count;
	logic full, bsel, bin;
	logic [2:0] bep;
	logic [5:0] bofs;
	logic [9:0] wexp [4] = '{10'h200, 10'h37f, 10'h000, 10'h17f};
	logic [7:0] q [$];
	logic [15:0] regs [8] = '{ADDR_IN_REQ, ADDR_OUT_REQ, ADDR_BUS_REQ,
		ADDR_IN_EN, ADDR_OUT_EN, ADDR_BUS_EN, ADDR_ISO_CRC_ERR, ADDR_ISO_ZERO_LEN};
	logic [15:0] wins [6] = '{16'hc700, 16'hc4bf, 16'hc6c0, 16'hc47f,
		16'hc740, 16'hc7b0};
	int n_mismatch = 0;
	int comparisons = 0;
	int n;
	always #5 i_sys_clk = ~i_sys_clk;
	usbirq_regs dut (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_in_ack(in_ack), .i_out_ok(out_ok), .i_bus_event(bus_ev),
		.i_iso_out_valid(iv), .i_iso_out_byte(ib), .i_iso_out_end(ie),
		.i_iso_out_crc_bad(ic), .i_iso_in_pop(ip), .o_iso_in_byte,
		.o_iso_in_count, .o_iso_out_full(full), .o_buf_sel(bsel),
		.o_buf_is_in(bin), .o_buf_ep(bep), .o_buf_ofs(bofs), .o_ivec,
		.o_usb_irq);
	usbirq_link_model link (.i_sys_clk, .o_in_ack(in_ack), .o_out_ok(out_ok),
		.o_bus_event(bus_ev), .o_valid(iv), .o_byte(ib), .o_end(ie),
		.o_crc_bad(ic), .o_pop(ip));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask : chk
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 chk($sformatf("read %h", a), o_rdata, e);
	endtask : rd
	task automatic wait_irq();
		int t = 0;
		while (o_usb_irq !== 1'b1) begin
			@(posedge i_sys_clk);
			#1;
			if (++t > 20) begin
				chk("irq wait", 16'h0000, 16'h0001);
				finish_test();
			end
		end
	endtask : wait_irq
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h175b));
		repeat (12) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		foreach (regs[i]) rd(regs[i], 8'h00);
		for (int i = 3; i < 6; i++) begin
			v = $urandom;
			wr(regs[i], v);
			rd(regs[i], v & (i == 5 ? 8'h1f : 8'h3f));
		end
		wr(ADDR_IN_EN, 8'h3f);
		wr(ADDR_OUT_EN, 8'h3f);
		wr(ADDR_BUS_EN, 8'h1f);
		link.ev('1);
		// Each clear must bring the next source forward with a fresh pulse
		for (int k = 0; k < 17; k++) begin
			wait_irq();
			repeat (2) @(posedge i_sys_clk);
			chk("vector", o_ivec, 16'(k < 5 ? 4 * k : 24 + 4 * (k - 5)));
			wr(k < 5 ? ADDR_BUS_REQ : (k % 2 ? ADDR_IN_REQ : ADDR_OUT_REQ),
				8'h01 << (k < 5 ? k : (k - 5) / 2));
		end
		repeat (5) begin
			@(posedge i_sys_clk);
			#1 chk("idle irq", o_usb_irq, 16'h0000);
		end
		rd(ADDR_BUS_REQ, 8'h00);
		for (int i = 3; i < 6; i++) wr(regs[i], 8'h00);
		link.ev(17'h0_2000);
		repeat (6) begin
			@(posedge i_sys_clk);
			#1 chk("masked irq", o_usb_irq, 16'h0000);
		end
		rd(ADDR_BUS_REQ, 8'h02);
		wr(ADDR_BUS_REQ, 8'h00);
		rd(ADDR_BUS_REQ, 8'h02);
		fork
			link.ev(17'h0_2000);
			wr(ADDR_BUS_REQ, 8'h02);
		join
		rd(ADDR_BUS_REQ, 8'h02);
		wr(ADDR_BUS_REQ, 8'h02);
		rd(ADDR_BUS_REQ, 8'h00);
		for (int i = 0; i < 3; i++) begin
			n = i == 2 ? 0 : $urandom_range(1, 20);
			v = i == 0 ? 8'h01 : 8'(i == 1 && $urandom_range(1));
			link.pkt(n, v[0]);
			link.ev(17'h0_2000);
			rd(ADDR_ISO_CNT_HIGH, 8'h00);
			rd(ADDR_ISO_CNT_LOW, 8'(n));
			rd(ADDR_ISO_CRC_ERR, v);
			rd(ADDR_ISO_ZERO_LEN, 8'(n == 0));
			repeat (n) rd(ADDR_ISO_OUT_DATA, link.q.pop_front());
		end
		link.pkt(ISO_FIFO_BYTES + 2, 1'b0);
		#1 chk("out full", full, 16'h0001);
		link.ev(17'h0_2000);
		rd(ADDR_ISO_CNT_LOW, 8'(ISO_FIFO_BYTES));
		repeat (ISO_FIFO_BYTES) rd(ADDR_ISO_OUT_DATA, link.q.pop_front());
		link.q.delete();
		#1 chk("out full", full, 16'h0000);
		n = $urandom_range(1, 10);
		repeat (n) begin
			v = $urandom;
			q.push_back(v);
			wr(ADDR_ISO_IN_DATA, v);
		end
		@(posedge i_sys_clk);
		#1 chk("in count", o_iso_in_count, 16'(n));
		repeat (n) begin
			link.pop();
			#1 chk("in byte", o_iso_in_byte, q.pop_front());
		end
		// Bulk windows stay inside the 768-byte span c440..c73f
		foreach (wins[i]) begin
			@(posedge i_sys_clk);
			i_addr <= wins[i];
			i_wr <= 1'b1;
			#1 chk("buf sel", bsel, 16'(i < 4));
			if (i < 4) chk("buf map", {bin, bep, bofs}, wexp[i]);
			@(posedge i_sys_clk);
			i_wr <= 1'b0;
		end
		rd(16'hc7b0, 8'h00);
		finish_test();
	end
endmodule : tb_top
